/* File: src/supply_monitor_reset_logic.sv */
`timescale 1ns/1ns
`default_nettype none
module supply_monitor_reset_logic
  import supervisor_pkg::*;
#(
  parameter int CNT_WIDTH   = 32,
  parameter int DELAY_CYC   = DELAY_DEFAULT_CYC,
  parameter int TIMEOUT_CYC = TIMEOUT_DEFAULT_CYC
) (
  input  wire logic        CLK,
  input  wire logic        RST,
  input  wire logic [3:0]  CHAN_ENABLE,
  input  wire logic [3:0]  CHAN_UV_GOOD,
  input  wire logic [3:0]  CHAN_OV_GOOD,
  input  wire logic        MANUAL_RESET_N,
  output logic [3:0]       CHAN_STATUS_OUT,
  output logic             SYS_RESET,
  output logic             SYS_RESET_N,
  input  wire logic [7:0]  S_AXI_AWADDR,
  input  wire logic        S_AXI_AWVALID,
  output logic             S_AXI_AWREADY,
  input  wire logic [31:0] S_AXI_WDATA,
  input  wire logic [3:0]  S_AXI_WSTRB,
  input  wire logic        S_AXI_WVALID,
  output logic             S_AXI_WREADY,
  output logic [1:0]       S_AXI_BRESP,
  output logic             S_AXI_BVALID,
  input  wire logic        S_AXI_BREADY,
  input  wire logic [7:0]  S_AXI_ARADDR,
  input  wire logic        S_AXI_ARVALID,
  output logic             S_AXI_ARREADY,
  output logic [31:0]      S_AXI_RDATA,
  output logic [1:0]       S_AXI_RRESP,
  output logic             S_AXI_RVALID,
  input  wire logic        S_AXI_RREADY
);

  if (CNT_WIDTH < 2 || CNT_WIDTH > 32 || DELAY_CYC < 0 || TIMEOUT_CYC < 1 ||
      (CNT_WIDTH < 32 && ((DELAY_CYC >> CNT_WIDTH) != 0 || (TIMEOUT_CYC >> CNT_WIDTH) != 0))) begin : g_bad_params
    $error("unsupported parameter values");
  end

  typedef struct packed {
    logic [3:0]            en_s1;
    logic [3:0]            en_s2;
    logic                  mr_s1;
    logic                  mr_s2;
    logic [2:0]            control;
    logic [CNT_WIDTH-1:0]  delay1;
    logic [CNT_WIDTH-1:0]  delay2;
    logic [CNT_WIDTH-1:0]  delay3;
    logic [CNT_WIDTH-1:0]  delay4;
    logic [CNT_WIDTH-1:0]  timeout;
    logic [CNT_WIDTH-1:0]  hold_count;
    rst_state_t            rst_state;
    logic [3:0]            status_out;
    logic                  sys_reset;
    logic                  sys_reset_n;
    logic                  awready;
    logic                  wready;
    logic                  arready;
    logic                  aw_held;
    logic [7:0]            aw_addr;
    logic                  w_held;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } top_state_t;

  top_state_t s;
  top_state_t n;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [CNT_WIDTH-1:0] merge(input logic [CNT_WIDTH-1:0] old,
                                                 input logic [31:0] data,
                                                 input logic [3:0] strb);
    logic [31:0] wide;
    wide = 32'h0;
    wide[CNT_WIDTH-1:0] = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        wide[b*8 +: 8] = data[b*8 +: 8];
      end
    end
    return wide[CNT_WIDTH-1:0];
  endfunction

  function automatic logic [31:0] widen(input logic [CNT_WIDTH-1:0] v);
    logic [31:0] w;
    w = 32'h0;
    w[CNT_WIDTH-1:0] = v;
    return w;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    return a == ADDR_CONTROL || a == ADDR_STATUS || a == ADDR_DELAY1 || a == ADDR_DELAY2 ||
           a == ADDR_DELAY3 || a == ADDR_DELAY4 || a == ADDR_TIMEOUT;
  endfunction

  // ------------------------------------------------------------
  // channel qualification
  // ------------------------------------------------------------
  logic       pairing;
  logic       polarity;
  logic [3:0] en;
  logic [3:0] good;
  logic [3:0] ready;
  logic [CNT_WIDTH-1:0] dly [4];

  assign pairing  = s.control[CTL_PAIRING];
  assign polarity = s.control[CTL_POLARITY];
  assign en       = s.en_s2;
  assign dly[0]   = s.delay1;
  assign dly[1]   = s.delay2;
  assign dly[2]   = s.delay3;
  assign dly[3]   = s.delay4;

  // comparator flags are already synchronous to CLK
  always_comb begin
    // pairing folds the overvoltage check of chan3/4 into chan1/2
    good[0] = en[0] && CHAN_UV_GOOD[0] && (!pairing || (en[2] && CHAN_OV_GOOD[2]));
    good[1] = en[1] && CHAN_UV_GOOD[1] && (!pairing || (en[3] && CHAN_OV_GOOD[3]));
    good[2] = !pairing && en[2] && CHAN_UV_GOOD[2];
    good[3] = !pairing && en[3] && CHAN_UV_GOOD[3];
  end

  // one counter per channel; each restarts when its channel goes bad
  for (genvar i = 0; i < 4; i++) begin : g_chan
    release_delay #(
      .WIDTH (CNT_WIDTH)
    ) u_delay (
      .clk    (CLK),
      .rst    (RST),
      .good   (good[i]),
      .length (dly[i]),
      .valid  (ready[i])
    );
  end

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  logic cause;
  logic wr_fire;
  logic [7:0]  wa;
  logic [31:0] wd;
  logic [3:0]  ws;

  always_comb begin
    n = s;
    wa = s.aw_held ? s.aw_addr : S_AXI_AWADDR;
    wd = s.w_held ? s.w_data : S_AXI_WDATA;
    ws = s.w_held ? s.w_strb : S_AXI_WSTRB;

    // two-stage synchronisers for board pins
    n.en_s1 = CHAN_ENABLE;
    n.en_s2 = s.en_s1;
    n.mr_s1 = MANUAL_RESET_N;
    n.mr_s2 = s.mr_s1;

    // paired chan3/4 outputs are held low, whatever the polarity
    n.status_out[0] = ready[0];
    n.status_out[1] = ready[1];
    n.status_out[2] = (pairing || !en[2]) ? 1'b0 : (ready[2] ^ polarity);
    n.status_out[3] = (pairing || !en[3]) ? 1'b0 : (ready[3] ^ polarity);

    // any failed channel (chan3/4 undervoltage only when unpaired), dropped enable, manual or software reset
    cause = !(&ready[1:0]) || !(&en[1:0]) || !s.mr_s2 || s.control[CTL_SW_RESET] ||
            (!pairing && (!(&ready[3:2]) || !(&en[3:2])));
    case (s.rst_state)
      RST_ASSERTED: begin
        n.sys_reset = 1'b1;
        if (!cause) begin
          n.rst_state  = RST_HOLDOFF;
          n.hold_count = '0;
        end
      end
      RST_HOLDOFF: begin
        n.sys_reset = 1'b1;
        if (cause) begin
          n.rst_state = RST_ASSERTED;
        end else if (s.hold_count + 1'b1 >= s.timeout) begin
          n.rst_state = RST_RELEASED;
          n.sys_reset = 1'b0;
        end else begin
          n.hold_count = s.hold_count + 1'b1;
        end
      end
      RST_RELEASED: begin
        n.sys_reset = 1'b0;
        if (cause) begin
          n.rst_state = RST_ASSERTED;
          n.sys_reset = 1'b1;
        end
      end
      default: begin
        n.rst_state = RST_ASSERTED;
        n.sys_reset = 1'b1;
      end
    endcase

    // ----------------------------------------------------------
    // axi4-lite write
    // ----------------------------------------------------------
    if (S_AXI_AWVALID && !s.aw_held && !s.bvalid) begin
      n.aw_held = 1'b1;
      n.aw_addr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && !s.w_held && !s.bvalid) begin
      n.w_held = 1'b1;
      n.w_data = S_AXI_WDATA;
      n.w_strb = S_AXI_WSTRB;
    end
    wr_fire = !s.bvalid && (s.aw_held || S_AXI_AWVALID) && (s.w_held || S_AXI_WVALID);
    if (wr_fire) begin
      n.aw_held = 1'b0;
      n.w_held  = 1'b0;
      n.bvalid  = 1'b1;
      n.bresp   = mapped(wa) ? RESP_OKAY : RESP_SLVERR;
      case (wa)
        ADDR_CONTROL: if (ws[0]) n.control = wd[2:0];
        ADDR_DELAY1:  n.delay1 = merge(s.delay1, wd, ws);
        ADDR_DELAY2:  n.delay2 = merge(s.delay2, wd, ws);
        ADDR_DELAY3:  n.delay3 = merge(s.delay3, wd, ws);
        ADDR_DELAY4:  n.delay4 = merge(s.delay4, wd, ws);
        ADDR_TIMEOUT: n.timeout = merge(s.timeout, wd, ws);
        default: ;
      endcase
    end else if (s.bvalid && S_AXI_BREADY) begin
      n.bvalid = 1'b0;
    end

    // ----------------------------------------------------------
    // axi4-lite read
    // ----------------------------------------------------------
    if (s.rvalid) begin
      if (S_AXI_RREADY) begin
        n.rvalid = 1'b0;
      end
    end else if (S_AXI_ARVALID) begin
      n.rvalid = 1'b1;
      n.rresp  = mapped(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
      case (S_AXI_ARADDR)
        ADDR_CONTROL: n.rdata = {29'h0, s.control};
        ADDR_STATUS: begin
          n.rdata = 32'h0;
          n.rdata[ST_OUT_LSB +: 4] = s.status_out;
          n.rdata[ST_SYS_RST]      = s.sys_reset;
          n.rdata[ST_EN_LSB +: 4]  = en;
          n.rdata[ST_MR_N]         = s.mr_s2;
        end
        ADDR_DELAY1:  n.rdata = widen(s.delay1);
        ADDR_DELAY2:  n.rdata = widen(s.delay2);
        ADDR_DELAY3:  n.rdata = widen(s.delay3);
        ADDR_DELAY4:  n.rdata = widen(s.delay4);
        ADDR_TIMEOUT: n.rdata = widen(s.timeout);
        default:      n.rdata = 32'h0;
      endcase
    end
    n.sys_reset_n = !n.sys_reset;
    n.awready     = !n.aw_held && !n.bvalid;
    n.wready      = !n.w_held && !n.bvalid;
    n.arready     = !n.rvalid;
  end

  // the manual reset synchroniser resets high: an idle pin reads inactive
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s            <= '0;
      s.mr_s1      <= 1'b1;
      s.mr_s2      <= 1'b1;
      s.control    <= CONTROL_RESET;
      s.delay1     <= CNT_WIDTH'(DELAY_CYC);
      s.delay2     <= CNT_WIDTH'(DELAY_CYC);
      s.delay3     <= CNT_WIDTH'(DELAY_CYC);
      s.delay4     <= CNT_WIDTH'(DELAY_CYC);
      s.timeout    <= CNT_WIDTH'(TIMEOUT_CYC);
      s.rst_state  <= RST_ASSERTED;
      s.sys_reset  <= 1'b1;
      s.awready    <= 1'b1;
      s.wready     <= 1'b1;
      s.arready    <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // ------------------------------------------------------------
  // outputs, all from flops
  // ------------------------------------------------------------
  assign CHAN_STATUS_OUT = s.status_out;
  assign SYS_RESET       = s.sys_reset;
  assign SYS_RESET_N     = s.sys_reset_n;
  assign S_AXI_AWREADY   = s.awready;
  assign S_AXI_WREADY    = s.wready;
  assign S_AXI_BVALID    = s.bvalid;
  assign S_AXI_BRESP     = s.bresp;
  assign S_AXI_ARREADY   = s.arready;
  assign S_AXI_RVALID    = s.rvalid;
  assign S_AXI_RDATA     = s.rdata;
  assign S_AXI_RRESP     = s.rresp;

endmodule // supply_monitor_reset_logic
`default_nettype wire

/* File: src/supervisor_pkg.sv */
package supervisor_pkg;

  // ------------------------------------------------------------
  // register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_DELAY1  = 8'h08;
  localparam logic [7:0] ADDR_DELAY2  = 8'h0C;
  localparam logic [7:0] ADDR_DELAY3  = 8'h10;
  localparam logic [7:0] ADDR_DELAY4  = 8'h14;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h18;

  // ------------------------------------------------------------
  // control fields
  // ------------------------------------------------------------
  localparam int CTL_PAIRING  = 0;
  localparam int CTL_POLARITY = 1;
  localparam int CTL_SW_RESET = 2;
  localparam logic [2:0] CONTROL_RESET = 3'h0;

  // status fields
  localparam int ST_OUT_LSB  = 0;
  localparam int ST_SYS_RST  = 4;
  localparam int ST_EN_LSB   = 5;
  localparam int ST_MR_N     = 9;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int DELAY_DEFAULT_US   = 200;
  localparam int TIMEOUT_DEFAULT_US = 1000;
  localparam int DELAY_DEFAULT_CYC   = DELAY_DEFAULT_US * 1000 / CLK_PERIOD_NS;
  localparam int TIMEOUT_DEFAULT_CYC = TIMEOUT_DEFAULT_US * 1000 / CLK_PERIOD_NS;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    RST_ASSERTED,
    RST_HOLDOFF,
    RST_RELEASED
  } rst_state_t;

endpackage

/* File: src/release_delay.sv */
`timescale 1ns/1ns
`default_nettype none
module release_delay
  import supervisor_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             good,
  input  wire logic [WIDTH-1:0] length,
  output logic                  valid
);

  typedef struct packed {
    logic [WIDTH-1:0] count;
    logic             valid;
  } delay_state_t;

  delay_state_t state;
  delay_state_t next_state;

  // bad input drops the output at once and restarts the count
  always_comb begin
    next_state = state;
    if (!good) begin
      next_state.count = '0;
      next_state.valid = 1'b0;
    end else if (!state.valid) begin
      if (state.count >= length) begin
        next_state.valid = 1'b1;
      end else begin
        next_state.count = state.count + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign valid = state.valid;

endmodule // release_delay
`default_nettype wire

/* File: bench/board_side.sv */
`timescale 1ns/1ns
`default_nettype none
module board_side (
  input  wire logic mr_drive,
  input  wire logic mr_level,
  output logic      mr_pin
);
  // undriven pin settles at the pull-up level
  assign mr_pin = mr_drive ? mr_level : 1'b1;
endmodule // board_side
`default_nettype wire

/* File: bench/supply_monitor_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
module monitor_checker #(
  parameter int DELAY_CYC   = 5,
  parameter int TIMEOUT_CYC = 10
) (
  input wire logic        CLK,
  input wire logic        RST,
  input wire logic [3:0]  CHAN_ENABLE,
  input wire logic [3:0]  CHAN_UV_GOOD,
  input wire logic        MANUAL_RESET_N,
  input wire logic [3:0]  CHAN_STATUS_OUT,
  input wire logic        SYS_RESET,
  input wire logic        SYS_RESET_N,
  input wire logic        S_AXI_BVALID,
  input wire logic        S_AXI_BREADY,
  input wire logic [1:0]  S_AXI_BRESP,
  input wire logic        S_AXI_RVALID,
  input wire logic        S_AXI_RREADY,
  input wire logic [31:0] S_AXI_RDATA
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  // ----
  // run lengths give lower bounds for delays
  // ----
  int good_run;
  int clear_run;
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      good_run  <= 0;
      clear_run <= 0;
    end else begin
      good_run  <= (CHAN_UV_GOOD[0] && CHAN_ENABLE[0]) ? good_run + 1 : 0;
      // causes that release needs gone, less chan3/4 and software reset: chan1/2 valid, enabled, no manual reset
      clear_run <= (MANUAL_RESET_N && (&CHAN_ENABLE[1:0]) && (&CHAN_STATUS_OUT[1:0])) ? clear_run + 1 : 0;
    end
  end
  property p_pair; SYS_RESET_N == !SYS_RESET; endproperty
  a_pair: assert property (p_pair) else $error("reset outputs disagree");
  property p_manual; !MANUAL_RESET_N [*8] |-> SYS_RESET && !SYS_RESET_N; endproperty
  a_manual: assert property (p_manual) else $error("manual reset ignored");
  property p_en1; !CHAN_ENABLE[0] [*6] |-> !CHAN_STATUS_OUT[0]; endproperty
  a_en1: assert property (p_en1) else $error("chan1 disable ignored");
  property p_en2; !CHAN_ENABLE[1] [*6] |-> !CHAN_STATUS_OUT[1]; endproperty
  a_en2: assert property (p_en2) else $error("chan2 disable ignored");
  property p_bad; !CHAN_UV_GOOD[0] [*5] |-> !CHAN_STATUS_OUT[0]; endproperty
  a_bad: assert property (p_bad) else $error("chan1 bad not shown");
  property p_cause; !CHAN_STATUS_OUT[1] [*6] |-> SYS_RESET; endproperty
  a_cause: assert property (p_cause) else $error("invalid chan2 no reset");
  property p_delay; $rose(CHAN_STATUS_OUT[0]) |-> good_run >= DELAY_CYC; endproperty
  a_delay: assert property (p_delay) else $error("chan1 valid too early");
  property p_hold; $fell(SYS_RESET) |-> clear_run >= TIMEOUT_CYC; endproperty
  a_hold: assert property (p_hold) else $error("reset released early");
  property p_bstay;
    S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID && $stable(S_AXI_BRESP);
  endproperty
  a_bstay: assert property (p_bstay) else $error("write response dropped");
  property p_rstay;
    S_AXI_RVALID && !S_AXI_RREADY |=> S_AXI_RVALID && $stable(S_AXI_RDATA);
  endproperty
  a_rstay: assert property (p_rstay) else $error("read response dropped");
  c_release: cover property ($fell(SYS_RESET));
  c_valid: cover property ($rose(CHAN_STATUS_OUT[0]));
  c_write: cover property (S_AXI_BVALID && S_AXI_BREADY);
endmodule // monitor_checker
bind supply_monitor_reset_logic monitor_checker #(
  .DELAY_CYC(DELAY_CYC),
  .TIMEOUT_CYC(TIMEOUT_CYC)
) checker_i (.*);
`default_nettype wire

/* File: bench/testbench.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench
  import supervisor_pkg::*;
;
  localparam int DLY = 5;
  localparam int TMO = 10;
  logic clk = 0, rst = 1, mr_drive = 0, mr_level = 1;
  logic [3:0] en = 4'hF, uv = 4'hF, ov = 4'hF, st, s_st;
  logic [7:0] aw_addr = 8'h00, ar_addr = 8'h00;
  logic [31:0] w_data = 32'h0, r_data;
  logic aw_valid = 0, w_valid = 0, b_ready = 0, ar_valid = 0, r_ready = 0;
  logic aw_ready, w_ready, b_valid, ar_ready, r_valid, sys_rst, sys_rst_n, s_rst, s_rstn;
  logic [1:0] b_resp, r_resp, r;
  logic [31:0] d;
  wire logic mr_pin;
  int num_errors = 0, n_compared = 0;
  board_side pins (.mr_drive(mr_drive), .mr_level(mr_level), .mr_pin(mr_pin));
  supply_monitor_reset_logic #(.DELAY_CYC(DLY), .TIMEOUT_CYC(TMO)) dut (
    .CLK(clk), .RST(rst), .CHAN_ENABLE(en), .CHAN_UV_GOOD(uv), .CHAN_OV_GOOD(ov),
    .MANUAL_RESET_N(mr_pin), .CHAN_STATUS_OUT(st), .SYS_RESET(sys_rst), .SYS_RESET_N(sys_rst_n),
    .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
    .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_valid), .S_AXI_WREADY(w_ready),
    .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid), .S_AXI_BREADY(b_ready),
    .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid), .S_AXI_ARREADY(ar_ready),
    .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp), .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready));
  initial forever #5 clk = ~clk;
  // pins seen just before each rising edge, free of edge races
  always @(negedge clk) {s_st, s_rst, s_rstn} = {st, sys_rst, sys_rst_n};
  // ----
  // access tasks
  // ----
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic aw_hs, w_hs, hs;
    aw_addr <= a;
    w_data <= v;
    aw_valid <= 1'b1;
    w_valid <= 1'b1;
    do begin
      @(negedge clk);
      aw_hs = aw_valid && aw_ready;
      w_hs = w_valid && w_ready;
      @(posedge clk);
      aw_valid <= aw_valid && !aw_hs;
      w_valid <= w_valid && !w_hs;
    end while ((aw_valid && !aw_hs) || (w_valid && !w_hs));
    @(posedge clk);
    b_ready <= 1'b1;
    do begin
      @(negedge clk);
      hs = b_valid;
      rs = b_resp;
      @(posedge clk);
    end while (!hs);
    b_ready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic hs;
    ar_addr <= a;
    ar_valid <= 1'b1;
    do begin
      @(negedge clk);
      hs = ar_ready;
      @(posedge clk);
    end while (!hs);
    ar_valid <= 1'b0;
    @(posedge clk);
    r_ready <= 1'b1;
    do begin
      @(negedge clk);
      hs = r_valid;
      v = r_data;
      rs = r_resp;
      @(posedge clk);
    end while (!hs);
    r_ready <= 1'b0;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    rd(a, d, r);
    chk(nm, e, d);
    chk(nm, RESP_OKAY, r);
  endtask
  task automatic conclude;
    $display("compared %0d mismatched %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    conclude();
  end
  // ----
  // tests
  // ----
  initial begin
    repeat (4) @(posedge clk);
    chk("reset pins", 32'h2, {s_rst, s_rstn});
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("control", ADDR_CONTROL, 32'h0);
    rchk("delay1", ADDR_DELAY1, DLY);
    rchk("timeout", ADDR_TIMEOUT, TMO);
    rd(8'h1C, d, r);
    chk("unmapped rd data", 32'h0, d);
    chk("unmapped rd resp", RESP_SLVERR, r);
    wr(8'h1C, 32'h1, r);
    chk("unmapped wr", RESP_SLVERR, r);
    $display("test registers done");
    repeat (40) @(posedge clk);
    chk("status", 4'hF, s_st);
    chk("released", 32'h1, {s_rst, s_rstn});
    uv[0] <= 1'b0;
    repeat (6) @(posedge clk);
    chk("chan1 bad", {2'b01}, {s_st[0], s_rst});
    uv[0] <= 1'b1;
    repeat (DLY) @(posedge clk);
    chk("chan1 early", 0, s_st[0]);
    repeat (4) @(posedge clk);
    chk("chan1 late", {2'b11}, {s_st[0], s_rst});
    repeat (TMO + 6) @(posedge clk);
    chk("holdoff end", 0, s_rst);
    $display("test delays done");
    for (int ch = 0; ch < 4; ch++) begin
      en[ch] <= 1'b0;
      repeat (8) @(posedge clk);
      chk("disabled", {2'b01}, {s_st[ch], s_rst});
      en[ch] <= 1'b1;
      repeat (DLY + TMO + 12) @(posedge clk);
    end
    $display("test enables done");
    wr(ADDR_CONTROL, 32'h2, r);
    repeat (4) @(posedge clk);
    chk("inverted", 4'h3, s_st);
    en[3] <= 1'b0;
    repeat (8) @(posedge clk);
    chk("inverted off", 0, s_st[3]);
    en[3] <= 1'b1;
    uv[3:2] <= 2'b00;
    repeat (8) @(posedge clk);
    chk("inverted bad", 4'hF, s_st);
    uv <= 4'hF;
    wr(ADDR_CONTROL, 32'h1, r);
    repeat (DLY + 8) @(posedge clk);
    chk("paired", 4'h3, s_st);
    ov[3] <= 1'b0;
    repeat (8) @(posedge clk);
    chk("chan4 over", 4'h1, s_st);
    ov[3] <= 1'b1;
    uv[3] <= 1'b0;
    ov[2] <= 1'b0;
    repeat (DLY + 8) @(posedge clk);
    chk("chan3 over", 4'h2, s_st);
    ov[2] <= 1'b1;
    uv[3] <= 1'b1;
    wr(ADDR_CONTROL, 32'h0, r);
    repeat (DLY + TMO + 12) @(posedge clk);
    $display("test modes done");
    mr_drive <= 1'b1;
    mr_level <= 1'b0;
    repeat (10) @(posedge clk);
    chk("manual", 32'h2, {s_rst, s_rstn});
    mr_drive <= 1'b0;
    repeat (TMO + 8) @(posedge clk);
    chk("manual end", 0, s_rst);
    wr(ADDR_CONTROL, 32'h4, r);
    chk("soft wr resp", RESP_OKAY, r);
    repeat (6) @(posedge clk);
    chk("soft reset", 32'h2, {s_rst, s_rstn});
    wr(ADDR_CONTROL, 32'h0, r);
    repeat (TMO + 8) @(posedge clk);
    chk("soft end", 0, s_rst);
    // status word: outputs 0xF, reset clear, enables 0xF, manual high
    rchk("status reg", ADDR_STATUS, 32'h3EF);
    wr(ADDR_DELAY1, 32'h14, r);
    rchk("delay1 new", ADDR_DELAY1, 32'h14);
    $display("test manual done");
    conclude();
  end
endmodule // testbench
`default_nettype wire
